// File: hdl/cfg_defs.svh
// constants for the configuration message agent
// Summary of operation
// - write with return address low byte all ones is done without any reply.
// - multi-byte fields travel most significant byte first.
// - local status register access moves one whole 32-bit word per instruction.
// - write is token 192, return address, register number, data, token 1.
// - write answer is tokens 3,1 on success or tokens 4,1 on failure.
// - read is token 193, return address, register number, token 1.
// - read answer is token 3, data word, token 1, or tokens 4,1 on failure.
`ifndef CFG_DEFS_SVH
`define CFG_DEFS_SVH
`define CFG_TOK_WRITE    8'hC0
`define CFG_TOK_READ     8'hC1
`define CFG_TOK_END      8'h01
`define CFG_TOK_ACK      8'h03
`define CFG_TOK_NAK      8'h04
`define CFG_NOREPLY_BYTE 8'hFF
`define CFG_PS_LOW_BYTE  8'h0C
`define CFG_RADDR_BYTES  3'h3
`define CFG_REG_BYTES    3'h2
`define CFG_DATA_BYTES   3'h4
`endif

// File: hdl/cfg_pkg.sv
// types for the configuration message agent
package cfg_pkg;
    typedef enum logic [3:0] {
        CFG_IDLE, CFG_RADDR, CFG_REGN, CFG_DATA, CFG_END, CFG_DRAIN,
        CFG_ACCESS, CFG_TX_HEAD, CFG_TX_DATA, CFG_TX_END
    } cfg_state_e;
endpackage

// File: hdl/cfg_ps_port.sv
// local processor status register word access path
`timescale 1ns/1ps
`include "cfg_defs.svh"
module cfg_ps_port
    import cfg_pkg::*;
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    // processor side
    input  wire logic        i_ps_valid,
    input  wire logic        i_ps_write,
    input  wire logic [15:0] i_ps_resource,
    input  wire logic [31:0] i_ps_wdata,
    output logic             o_ps_done,
    output logic [31:0]      o_ps_rdata,
    output logic             o_ps_error,
    // register file side
    output logic             o_req,
    output logic             o_write,
    output logic [7:0]       o_regnum,
    output logic [31:0]      o_wdata,
    input  wire logic        i_done,
    input  wire logic        i_ok,
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_grant
);
    // ----------------------------------------
    // resource decode
    // ----------------------------------------
    logic bad_low;
    logic busy_q;
    assign bad_low = (i_ps_resource[7:0] != `CFG_PS_LOW_BYTE);
    // busy holds the request off until valid drops, so one instruction gets one access
    assign o_req    = i_ps_valid & ~bad_low & i_grant & ~busy_q;
    assign o_write  = i_ps_write;
    assign o_regnum = i_ps_resource[15:8];
    assign o_wdata  = i_ps_wdata;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ps_done  <= 1'b0;
            o_ps_error <= 1'b0;
            o_ps_rdata <= 32'h0000_0000;
            busy_q     <= 1'b0;
        end else begin
            o_ps_done <= 1'b0;
            if (i_ps_valid && bad_low && !busy_q) begin
                o_ps_done  <= 1'b1;
                o_ps_error <= 1'b1;
                busy_q     <= 1'b1;
            end else if (o_req && i_done) begin
                o_ps_done  <= 1'b1;
                o_ps_error <= ~i_ok;
                o_ps_rdata <= i_rdata;
                busy_q     <= 1'b1;
            end else if (!i_ps_valid) begin
                busy_q <= 1'b0;
            end
        end
    end
endmodule

// File: hdl/cfg_agent.sv
// configuration message agent: token stream decoder, register access and reply
`timescale 1ns/1ps
`include "cfg_defs.svh"
module cfg_agent
    import cfg_pkg::*;
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    // incoming token stream
    input  wire logic        i_rx_valid,
    input  wire logic        i_rx_ctrl,
    input  wire logic [7:0]  i_rx_data,
    output logic             o_rx_ready,
    // outgoing token stream
    output logic             o_tx_valid,
    output logic             o_tx_ctrl,
    output logic [7:0]       o_tx_data,
    output logic [23:0]      o_tx_dest,
    input  wire logic        i_tx_ready,
    // local processor status access
    input  wire logic        i_ps_valid,
    input  wire logic        i_ps_write,
    input  wire logic [15:0] i_ps_resource,
    input  wire logic [31:0] i_ps_wdata,
    output logic             o_ps_done,
    output logic [31:0]      o_ps_rdata,
    output logic             o_ps_error,
    // register file
    output logic             o_reg_req,
    output logic             o_reg_write,
    output logic             o_reg_local,
    output logic [15:0]      o_reg_num,
    output logic [31:0]      o_reg_wdata,
    input  wire logic        i_reg_done,
    input  wire logic        i_reg_ok,
    input  wire logic [31:0] i_reg_rdata
);
    // ----------------------------------------
    // message state
    // ----------------------------------------
    cfg_state_e  state_q;
    logic        is_write_q;
    logic        bad_q;
    logic        ok_q;
    logic [2:0]  cnt_q;
    logic [23:0] raddr_q;
    logic [15:0] regn_q;
    logic [31:0] data_q;
    logic        rx_take;
    logic        tx_take;
    logic        msg_req;
    logic        ps_req;
    logic        ps_own_q;
    logic        ps_write;
    logic [7:0]  ps_reg;
    logic [31:0] ps_wdata;

    function automatic logic last_byte(input logic [2:0] cnt, input logic [2:0] n);
        last_byte = (cnt == n - 3'h1);
    endfunction

    assign rx_take    = i_rx_valid & o_rx_ready;
    assign tx_take    = o_tx_valid & i_tx_ready;
    // one message at a time: stop taking input once decoding is done
    assign o_rx_ready = (state_q != CFG_ACCESS) && (state_q != CFG_TX_HEAD) &&
                        (state_q != CFG_TX_DATA) && (state_q != CFG_TX_END);
    assign msg_req    = (state_q == CFG_ACCESS) && !bad_q && !ps_own_q;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q    <= CFG_IDLE;
            is_write_q <= 1'b0;
            bad_q      <= 1'b0;
            cnt_q      <= 3'h0;
        end else begin
            case (state_q)
                CFG_IDLE: begin
                    cnt_q <= 3'h0;
                    bad_q <= 1'b0;
                    if (rx_take && i_rx_ctrl && i_rx_data == `CFG_TOK_WRITE) begin
                        is_write_q <= 1'b1;
                        state_q    <= CFG_RADDR;
                    end else if (rx_take && i_rx_ctrl && i_rx_data == `CFG_TOK_READ) begin
                        is_write_q <= 1'b0;
                        state_q    <= CFG_RADDR;
                    end
                end
                CFG_RADDR: if (rx_take) begin
                    if (i_rx_ctrl) begin
                        bad_q   <= 1'b1;
                        state_q <= (i_rx_data == `CFG_TOK_END) ? CFG_ACCESS : CFG_DRAIN;
                    end else if (last_byte(cnt_q, `CFG_RADDR_BYTES)) begin
                        cnt_q   <= 3'h0;
                        state_q <= CFG_REGN;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
                CFG_REGN: if (rx_take) begin
                    if (i_rx_ctrl) begin
                        bad_q   <= 1'b1;
                        state_q <= (i_rx_data == `CFG_TOK_END) ? CFG_ACCESS : CFG_DRAIN;
                    end else if (last_byte(cnt_q, `CFG_REG_BYTES)) begin
                        cnt_q   <= 3'h0;
                        state_q <= is_write_q ? CFG_DATA : CFG_END;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
                CFG_DATA: if (rx_take) begin
                    if (i_rx_ctrl) begin
                        bad_q   <= 1'b1;
                        state_q <= (i_rx_data == `CFG_TOK_END) ? CFG_ACCESS : CFG_DRAIN;
                    end else if (last_byte(cnt_q, `CFG_DATA_BYTES)) begin
                        cnt_q   <= 3'h0;
                        state_q <= CFG_END;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
                CFG_END: if (rx_take) begin
                    // a data byte where the closing token belongs makes the message fail
                    if (!(i_rx_ctrl && i_rx_data == `CFG_TOK_END)) begin
                        bad_q <= 1'b1;
                    end
                    state_q <= (i_rx_ctrl && i_rx_data == `CFG_TOK_END) ? CFG_ACCESS : CFG_DRAIN;
                end
                CFG_DRAIN: if (rx_take && i_rx_ctrl && i_rx_data == `CFG_TOK_END) begin
                    state_q <= CFG_ACCESS;
                end
                CFG_ACCESS: if (bad_q || (msg_req && i_reg_done)) begin
                    if (is_write_q && raddr_q[7:0] == `CFG_NOREPLY_BYTE) begin
                        state_q <= CFG_IDLE;
                    end else begin
                        state_q <= CFG_TX_HEAD;
                    end
                end
                CFG_TX_HEAD: if (tx_take) begin
                    cnt_q   <= 3'h0;
                    state_q <= (!is_write_q && ok_q) ? CFG_TX_DATA : CFG_TX_END;
                end
                CFG_TX_DATA: if (tx_take) begin
                    if (last_byte(cnt_q, `CFG_DATA_BYTES)) begin
                        state_q <= CFG_TX_END;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
                CFG_TX_END: if (tx_take) begin
                    state_q <= CFG_IDLE;
                end
                default: state_q <= CFG_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // field capture, most significant byte first
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            raddr_q <= 24'h00_0000;
            regn_q  <= 16'h0000;
            data_q  <= 32'h0000_0000;
        end else if (rx_take && !i_rx_ctrl) begin
            if (state_q == CFG_RADDR) begin
                raddr_q <= {raddr_q[15:0], i_rx_data};
            end
            if (state_q == CFG_REGN) begin
                regn_q <= {regn_q[7:0], i_rx_data};
            end
            if (state_q == CFG_DATA) begin
                data_q <= {data_q[23:0], i_rx_data};
            end
        end else if (msg_req && i_reg_done) begin
            data_q <= is_write_q ? data_q : i_reg_rdata;
        end else if (state_q == CFG_TX_DATA && tx_take) begin
            data_q <= {data_q[23:0], 8'h00};
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            ok_q <= 1'b0;
        end else if (state_q == CFG_ACCESS) begin
            ok_q <= !bad_q && i_reg_ok;
        end
    end

    // ----------------------------------------
    // reply stream
    // ----------------------------------------
    assign o_tx_valid = (state_q == CFG_TX_HEAD) || (state_q == CFG_TX_DATA) || (state_q == CFG_TX_END);
    assign o_tx_ctrl  = (state_q != CFG_TX_DATA);
    assign o_tx_dest  = raddr_q;
    always_comb begin
        case (state_q)
            CFG_TX_HEAD: o_tx_data = ok_q ? `CFG_TOK_ACK : `CFG_TOK_NAK;
            CFG_TX_DATA: o_tx_data = data_q[31:24];
            CFG_TX_END:  o_tx_data = `CFG_TOK_END;
            default:     o_tx_data = 8'h00;
        endcase
    end

    // ----------------------------------------
    // register file arbitration; messages win when both start together, otherwise a local access already under way keeps the port
    // ----------------------------------------
    assign o_reg_req   = msg_req | ps_req;
    assign o_reg_local = ~msg_req;
    assign o_reg_write = msg_req ? is_write_q : ps_write;
    assign o_reg_num   = msg_req ? regn_q : {8'h00, ps_reg};
    assign o_reg_wdata = msg_req ? data_q : ps_wdata;

    // a local access already under way keeps the port; a message cutting in would change
    // the register number in the middle of an access
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            ps_own_q <= 1'b0;
        end else begin
            ps_own_q <= ps_req && !i_reg_done;
        end
    end

    cfg_ps_port u_ps (
        .i_clock       (i_clock),
        .i_rstn        (i_rstn),
        .i_ps_valid    (i_ps_valid),
        .i_ps_write    (i_ps_write),
        .i_ps_resource (i_ps_resource),
        .i_ps_wdata    (i_ps_wdata),
        .o_ps_done     (o_ps_done),
        .o_ps_rdata    (o_ps_rdata),
        .o_ps_error    (o_ps_error),
        .o_req         (ps_req),
        .o_write       (ps_write),
        .o_regnum      (ps_reg),
        .o_wdata       (ps_wdata),
        .i_done        (i_reg_done),
        .i_ok          (i_reg_ok),
        .i_rdata       (i_reg_rdata),
        .i_grant       (~msg_req)
    );
endmodule

// File: tb/cfg_agent_properties.sv
// port assertions for the configuration message agent
`timescale 1ns/1ps
module cfg_agent_checker (
    // watched ports
    input wire logic        i_clock,
    input wire logic        i_rstn,
    input wire logic        o_rx_ready,
    input wire logic        o_tx_valid,
    input wire logic        o_tx_ctrl,
    input wire logic [7:0]  o_tx_data,
    input wire logic [23:0] o_tx_dest,
    input wire logic        i_tx_ready,
    input wire logic        o_ps_done,
    input wire logic        o_reg_req,
    input wire logic        o_reg_write,
    input wire logic        o_reg_local,
    input wire logic [15:0] o_reg_num,
    input wire logic        i_reg_done,
    input wire logic        i_reg_ok
);
    // ----------------------------------------
    // message access completion
    // ----------------------------------------
    logic fin;
    assign fin = o_reg_req && i_reg_done && !o_reg_local;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    a_req_holds: assert property (o_reg_req && !i_reg_done |=> o_reg_req && $stable(o_reg_num))
        else $error("register request dropped or changed early");
    a_busy_no_rx: assert property ((o_reg_req && !o_reg_local) || o_tx_valid |-> !o_rx_ready)
        else $error("new tokens accepted while busy");
    a_tx_holds: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable({o_tx_ctrl, o_tx_data}))
        else $error("reply token changed before taken");
    a_ps_pulse: assert property (o_ps_done |=> !o_ps_done)
        else $error("status done longer than one cycle");
    a_ps_done_after: assert property (o_reg_req && i_reg_done && o_reg_local |=> o_ps_done)
        else $error("status access not completed");
    a_reply_head: assert property (fin && (!o_reg_write || o_tx_dest[7:0] != 8'hFF)
        |=> o_tx_valid && o_tx_ctrl && o_tx_data == ($past(i_reg_ok) ? 8'h03 : 8'h04))
        else $error("reply head wrong");
    a_no_reply: assert property (fin && o_reg_write && o_tx_dest[7:0] == 8'hFF |=> !o_tx_valid && o_rx_ready)
        else $error("reply sent for silent write");
    a_fail_end: assert property (o_tx_valid && i_tx_ready && o_tx_ctrl && o_tx_data == 8'h04
        |=> o_tx_valid && o_tx_ctrl && o_tx_data == 8'h01)
        else $error("failure not closed by end token");
    a_end_idle: assert property (o_tx_valid && i_tx_ready && o_tx_ctrl && o_tx_data == 8'h01
        |=> !o_tx_valid && o_rx_ready)
        else $error("not idle after reply end");
    c_write: cover property (fin && o_reg_write);
    c_read: cover property (fin && !o_reg_write);
    c_local: cover property (o_ps_done);
endmodule
bind cfg_agent cfg_agent_checker u_cfg_agent_checker (.i_clock, .i_rstn, .o_rx_ready, .o_tx_valid, .o_tx_ctrl,
    .o_tx_data, .o_tx_dest, .i_tx_ready, .o_ps_done, .o_reg_req, .o_reg_write, .o_reg_local, .o_reg_num,
    .i_reg_done, .i_reg_ok);

// File: tb/cfg_reg_model.sv
// register file model answering the agent after a set latency
`timescale 1ns/1ps
module cfg_reg_model (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    // agent side
    input  wire logic        i_req,
    input  wire logic        i_write,
    input  wire logic [15:0] i_num,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_delay,
    output logic             o_done,
    output logic             o_ok,
    output logic [31:0]      o_rdata
);
    logic [3:0]  cnt_q;
    logic [31:0] mem_q [16];
    // only sixteen registers exist, higher numbers answer failure
    assign o_ok    = (i_num < 16'h0010);
    assign o_done  = i_req && (cnt_q == i_delay);
    // outside done the data lines carry a pattern, not the last word
    assign o_rdata = o_done ? mem_q[i_num[3:0]] : 32'h5A5A_A5A5;
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn)
            cnt_q <= 4'h0;
        else
            cnt_q <= (i_req && !o_done) ? cnt_q + 4'h1 : 4'h0;
    end
    always_ff @(posedge i_clock) begin
        if (o_done && o_ok && i_write) mem_q[i_num[3:0]] <= i_wdata;
    end
endmodule

// File: tb/cfg_agent_tb.sv
// self-checking bench for the configuration message agent
`timescale 1ns/1ps
`include "cfg_defs.svh"
module cfg_agent_tb;
    logic        i_clock = 0, i_rstn = 0, i_rx_valid = 0, i_rx_ctrl = 0, i_tx_ready = 1;
    logic        i_ps_valid = 0, i_ps_write = 0, i_reg_done, i_reg_ok, stall = 0;
    logic [7:0]  i_rx_data = 0, o_tx_data;
    logic [15:0] i_ps_resource = 0, o_reg_num;
    logic [31:0] i_ps_wdata = 0, i_reg_rdata, o_ps_rdata, o_reg_wdata;
    logic        o_rx_ready, o_tx_valid, o_tx_ctrl, o_ps_done, o_ps_error, o_reg_req, o_reg_write, o_reg_local;
    logic [23:0] o_tx_dest;
    logic [3:0]  dly = 0;
    int          n_mismatch = 0, samples_checked = 0;
    // the bench is the requester; it aims its channel-end at a tile or a node configuration end
    localparam logic [31:0] dest_tile = 32'h0003_C20C;
    localparam logic [31:0] dest_node = 32'h0004_C30C;
    logic [31:0] dest = dest_tile;
    always #2.5 i_clock = ~i_clock;
    cfg_agent u_cfg_agent (.i_clock, .i_rstn, .i_rx_valid, .i_rx_ctrl, .i_rx_data, .o_rx_ready, .o_tx_valid,
        .o_tx_ctrl, .o_tx_data, .o_tx_dest, .i_tx_ready, .i_ps_valid, .i_ps_write, .i_ps_resource, .i_ps_wdata,
        .o_ps_done, .o_ps_rdata, .o_ps_error, .o_reg_req, .o_reg_write, .o_reg_local, .o_reg_num, .o_reg_wdata,
        .i_reg_done, .i_reg_ok, .i_reg_rdata);
    cfg_reg_model u_cfg_reg_model (.i_clock, .i_rstn, .i_req(o_reg_req), .i_write(o_reg_write), .i_num(o_reg_num),
        .i_wdata(o_reg_wdata), .i_delay(dly), .o_done(i_reg_done), .o_ok(i_reg_ok), .o_rdata(i_reg_rdata));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task put(input logic c, input logic [7:0] d);
        int k;
        k = 0;
        @(negedge i_clock);
        i_rx_valid = (dest[15:0] == 16'hC20C) || (dest[15:0] == 16'hC30C);
        i_rx_ctrl = c;
        i_rx_data = d;
        while (o_rx_ready !== 1'b1 && k < 100) begin
            @(negedge i_clock);
            k++;
        end
        chk("rx_ready", o_rx_ready, 1);
        @(posedge i_clock);
    endtask
    task rel;
        @(negedge i_clock);
        i_rx_valid = 0;
        i_rx_data = ~i_rx_data;
    endtask
    task msg(input logic [7:0] op, input logic [23:0] ra, input logic [15:0] rn, input logic [31:0] wd);
        put(1, op);
        for (int i = 2; i >= 0; i--) put(0, ra[i*8+:8]);
        for (int i = 1; i >= 0; i--) put(0, rn[i*8+:8]);
        if (op == `CFG_TOK_WRITE) for (int i = 3; i >= 0; i--) put(0, wd[i*8+:8]);
        put(1, `CFG_TOK_END);
        rel();
    endtask
    // a stalled sink holds ready low two cycles after the token shows, so the token is held three cycles and checked once
    task tok(input logic c, input logic [7:0] d);
        int k;
        k = 0;
        @(negedge i_clock);
        if (stall) i_tx_ready = 0;
        while (o_tx_valid !== 1'b1 && k < 200) begin
            @(negedge i_clock);
            k++;
        end
        if (stall) repeat (2) @(negedge i_clock);
        i_tx_ready = 1;
        chk("tx_valid", o_tx_valid, 1);
        chk("tx_ctrl", o_tx_ctrl, c);
        chk("tx_data", o_tx_data, d);
        @(posedge i_clock);
    endtask
    task wr(input logic [23:0] ra, input logic [15:0] rn, input logic [31:0] wd, input logic ok);
        msg(`CFG_TOK_WRITE, ra, rn, wd);
        chk("tx_dest", o_tx_dest, ra);
        tok(1, ok ? `CFG_TOK_ACK : `CFG_TOK_NAK);
        tok(1, `CFG_TOK_END);
    endtask
    task rd(input logic [23:0] ra, input logic [15:0] rn, input logic [31:0] ex, input logic ok);
        msg(`CFG_TOK_READ, ra, rn, 32'h0);
        chk("tx_dest", o_tx_dest, ra);
        tok(1, ok ? `CFG_TOK_ACK : `CFG_TOK_NAK);
        if (ok) for (int i = 3; i >= 0; i--) tok(0, ex[i*8+:8]);
        tok(1, `CFG_TOK_END);
    endtask
    task ps(input logic w, input logic [7:0] rn, input logic [7:0] lo, input logic [31:0] wd);
        int k;
        k = 0;
        @(negedge i_clock);
        i_ps_valid = 1;
        i_ps_write = w;
        i_ps_resource = {rn, lo};
        i_ps_wdata = wd;
        while (o_ps_done !== 1'b1 && k < 100) begin
            @(negedge i_clock);
            k++;
        end
        chk("ps_done", o_ps_done, 1);
        i_ps_valid = 0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_write_read;
        wr(24'h12_3456, 16'h0005, 32'h1234_5678, 1);
        dly = 4'h5;
        stall = 1;
        rd(24'h12_3457, 16'h0005, 32'h1234_5678, 1);
        stall = 0;
        dly = 4'h0;
    endtask
    task t_fail;
        dest = dest_node;
        rd(24'h00_2001, 16'h0200, 32'h0, 0);
        wr(24'h00_2002, 16'h0010, 32'h1, 0);
        dest = dest_tile;
    endtask
    task t_silent;
        logic sv;
        sv = 0;
        msg(`CFG_TOK_WRITE, 24'h00_21FF, 16'h0006, 32'hA5A5_5A5A);
        repeat (20) begin
            @(negedge i_clock);
            sv = sv | o_tx_valid;
        end
        chk("silent tx_valid", sv, 0);
        rd(24'h00_2103, 16'h0006, 32'hA5A5_5A5A, 1);
    endtask
    task t_short;
        put(1, `CFG_TOK_READ);
        put(0, 8'h00);
        put(1, `CFG_TOK_END);
        rel();
        tok(1, `CFG_TOK_NAK);
        tok(1, `CFG_TOK_END);
    endtask
    task t_local;
        ps(1, 8'h07, 8'h0C, 32'hCAFE_0001);
        chk("ps_error", o_ps_error, 0);
        ps(0, 8'h07, 8'h0C, 32'h0);
        chk("ps_rdata", o_ps_rdata, 32'hCAFE_0001);
        ps(0, 8'h07, 8'h0D, 32'h0);
        chk("ps_error", o_ps_error, 1);
        ps(0, 8'h20, 8'h0C, 32'h0);
        chk("ps_error", o_ps_error, 1);
    endtask
    initial begin
        repeat (3) @(negedge i_clock);
        i_rstn = 1;
        t_write_read();
        t_fail();
        t_silent();
        t_short();
        t_local();
        end_sim();
    end
    // all scenarios need well under a thousand cycles; 4000 means a hang
    initial begin
        #20000;
        n_mismatch++;
        end_sim();
    end
endmodule
